// ---- verilog/crb_cfg.svh ----
// Register offsets, reset values and logical device numbers of the config bank
`ifndef CRB_CFG_SVH
`define CRB_CFG_SVH
`define CRB_IDX_CONFIG_CTRL   8'h02
`define CRB_IDX_LDN           8'h07
`define CRB_IDX_DEV_ID        8'h20
`define CRB_IDX_DEV_REV       8'h21
`define CRB_IDX_POWER_CTRL    8'h22
`define CRB_IDX_GLOBAL_LAST   8'h2F
`define CRB_IDX_ACTIVATE      8'h30
`define CRB_IDX_BASE_HIGH     8'h60
`define CRB_IDX_BASE_LOW      8'h61
`define CRB_IDX_IRQ_PRI       8'h70
`define CRB_IDX_IRQ_SEC       8'h72
`define CRB_IDX_MODE_0        8'hF0
`define CRB_IDX_MODE_1        8'hF1
`define CRB_IDX_MODE_2        8'hF2
`define CRB_LD_SERIAL_ONE     8'h04
`define CRB_LD_SERIAL_TWO     8'h05
`define CRB_LD_KEYBOARD       8'h07
`define CRB_LD_GAME           8'h09
`define CRB_LD_WAKE           8'h0A
`define CRB_LD_MIDI           8'h0B
`define CRB_SOFT_RESET_BIT    0
`define CRB_PWR_STANDBY_MASK  8'hA0
`define CRB_RST_ZERO          8'h00
`define CRB_RST_MIDI_HIGH     8'h03
`define CRB_RST_MIDI_LOW      8'h30
`define CRB_RST_MIDI_IRQ      8'h05
`define CRB_RST_IR_OPTIONS    8'h02
`define CRB_RST_IR_TIMEOUT    8'h03
`endif

// ---- verilog/crb_pkg.sv ----
// Types shared by the configuration register bank
package crb_pkg;
	typedef logic [7:0] crb_byte_t;
	// Reset source that applies in a given cycle
	typedef enum logic [2:0] {
		CRB_RST_NONE    = 3'b000,
		CRB_RST_HARD    = 3'b001,
		CRB_RST_VCC     = 3'b010,
		CRB_RST_STANDBY = 3'b011,
		CRB_RST_SOFT    = 3'b100
	} crb_rst_t;
endpackage : crb_pkg

// ---- verilog/crb_config_bank.sv ----
// Configuration register bank reached through index and data ports
// Operation
// R1: Global registers occupy index 0x00 to 0x2F
// R2: All eight index bits decode, no aliasing
// R3: Unimplemented registers and bits: ignore writes, read zero
// R4: Index write selects, data access routes there
// R5: Ports respond only in configuration mode
// R6: Reserved registers are read-only zero
// R7: Power control bits 5,7 clear on standby only
// R8: MIDI base resets 0x03/0x30 on every source
// R9: Selector picks device for index 0x30 up
// R10: Activate write touches selected device only
// R11: Each reset loads its value or keeps contents
`timescale 1ns/100ps
`include "crb_cfg.svh"
module crb_config_bank
	import crb_pkg::*;
#(
	parameter logic [7:0] DEV_ID_VALUE  = 8'h5A, // Arbitrary identity value
	parameter logic [7:0] DEV_REV_VALUE = 8'h01  // Arbitrary revision value
) (
	input  wire logic       clk_sys,              // System clock, 200 MHz
	input  wire logic       reset,                // Hard reset, synchronous, high
	input  wire logic       main_poweron_reset,   // Main-supply power-on reset
	input  wire logic       standby_poweron_reset,// Standby-supply power-on reset
	input  wire logic       config_mode,          // Configuration mode entered
	input  wire logic       index_wr,             // Index port write strobe
	input  wire logic       data_wr,              // Data port write strobe
	input  wire logic       data_rd,              // Data port read strobe
	input  wire logic [7:0] wdata,                // Write data for either port
	output logic      [7:0] rdata,                // Read data, valid cycle after strobe
	output logic            rdata_valid,          // Pulse marking rdata
	output logic      [7:0] index_out,            // Current index
	output logic      [7:0] ldn_out,              // Selected logical device
	output logic      [7:0] power_ctrl_out,       // Chip power control
	output logic      [5:0] activate_out          // Activate bit 0 of ld4,5,7,9,wake,midi
);

	// Reset source, highest priority first; standby wins as it clears most
	crb_rst_t rst_src;
	always_comb begin
		if (standby_poweron_reset) begin
			rst_src = CRB_RST_STANDBY;
		end else if (main_poweron_reset) begin
			rst_src = CRB_RST_VCC;
		end else if (reset) begin
			rst_src = CRB_RST_HARD;
		end else begin
			rst_src = CRB_RST_NONE;
		end
	end

	logic [7:0] index_reg;      // Selected register number
	logic [7:0] ldn_reg;        // Selected logical device
	logic [7:0] power_ctrl_reg; // Chip power control
	logic       soft_reset_reg; // Soft reset pulse, self clearing
	logic       any_hw_rst;     // Any hardware reset source

	// Register storage per logical device
	logic [7:0] act_reg [6];                     // ld4, ld5, ld7, ld9, wake, midi
	logic [7:0] ld4_base_high_reg;               // Serial one base, high byte
	logic [7:0] ld4_base_low_reg;                // Serial one base, low byte
	logic [7:0] ld4_irq_select_reg;              // Serial one interrupt line
	logic [7:0] serial_one_mode_reg;             // Serial one mode
	logic [7:0] ld5_base_high_reg;               // Serial two base, high byte
	logic [7:0] ld5_base_low_reg;                // Serial two base, low byte
	logic [7:0] ld5_irq_select_reg;              // Serial two interrupt line
	logic [7:0] serial_two_mode_reg;             // Serial two mode
	logic [7:0] infrared_options_reg;            // Infrared options
	logic [7:0] infrared_halfduplex_timeout_reg; // Infrared turnaround timeout
	logic [7:0] keyboard_irq_select_reg;         // Keyboard interrupt line
	logic [7:0] pointer_irq_select_reg;          // Pointer interrupt line
	logic [7:0] keyboard_output_select_reg;      // Reset and address gate outputs
	logic [7:0] game_base_high_reg;              // Game port base, high byte
	logic [7:0] game_base_low_reg;               // Game port base, low byte
	logic [7:0] wake_block_base_high_reg;        // Wake block base, high byte
	logic [7:0] wake_block_base_low_reg;         // Wake block base, low byte
	logic [7:0] slow_clock_select_reg;           // Slow clock source, standby powered
	logic [7:0] midi_base_high_reg;              // MIDI base, high byte
	logic [7:0] midi_base_low_reg;               // MIDI base, low byte
	logic [7:0] midi_irq_select_reg;             // MIDI interrupt line

	assign any_hw_rst = (rst_src != CRB_RST_NONE);

	// Gated strobes: nothing answers outside configuration mode
	logic idx_we; // Index write taken
	logic dat_we; // Data write taken
	logic dat_re; // Data read taken
	assign idx_we = index_wr & config_mode; // R5
	assign dat_we = data_wr & config_mode;  // R5
	assign dat_re = data_rd & config_mode;  // R5

	// Full index compare, no bits ignored
	function automatic logic hit(input logic [7:0] idx, input logic [7:0] ld, input logic [7:0] off,
		input logic [7:0] dev);
		hit = (idx == off) && (ld == dev); // R2 R9
	endfunction : hit

	// Index register; reset clears it for a defined start
	// Soft reset leaves it alone: the host is mid-sequence at that point
	always_ff @(posedge clk_sys) begin
		if (any_hw_rst) begin
			index_reg <= `CRB_RST_ZERO;
		end else if (idx_we) begin
			index_reg <= wdata; // R4 R2
		end
	end

	// Soft reset request strobe clears itself one cycle later
	// Nothing is stored, so the control byte always reads back zero
	always_ff @(posedge clk_sys) begin
		if (any_hw_rst) begin
			soft_reset_reg <= 1'b0;
		end else begin
			soft_reset_reg <= dat_we && (index_reg == `CRB_IDX_CONFIG_CTRL)
				&& wdata[`CRB_SOFT_RESET_BIT];
		end
	end

	// Logical device selector resets on every source including soft
	always_ff @(posedge clk_sys) begin
		if (any_hw_rst || soft_reset_reg) begin
			ldn_reg <= `CRB_RST_ZERO; // R11
		end else if (dat_we && index_reg == `CRB_IDX_LDN) begin
			ldn_reg <= wdata; // R9
		end
	end

	// Power control; bits 5 and 7 survive all but the standby reset
	always_ff @(posedge clk_sys) begin
		if (rst_src == CRB_RST_STANDBY) begin
			power_ctrl_reg <= `CRB_RST_ZERO; // R7
		end else if (any_hw_rst || soft_reset_reg) begin
			power_ctrl_reg <= power_ctrl_reg & `CRB_PWR_STANDBY_MASK; // R7 R11
		end else if (dat_we && index_reg == `CRB_IDX_POWER_CTRL) begin
			power_ctrl_reg <= wdata;
		end
	end

	// Activate registers; ld5 has a value only for standby reset
	localparam logic [7:0] ACT_LD [6] = '{`CRB_LD_SERIAL_ONE, `CRB_LD_SERIAL_TWO,
		`CRB_LD_KEYBOARD, `CRB_LD_GAME, `CRB_LD_WAKE, `CRB_LD_MIDI};
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_act
			always_ff @(posedge clk_sys) begin
				if ((g == 1) ? (rst_src == CRB_RST_STANDBY) : (any_hw_rst || soft_reset_reg)) begin
					act_reg[g] <= `CRB_RST_ZERO; // R11
				end else if (dat_we && hit(index_reg, ldn_reg, `CRB_IDX_ACTIVATE, ACT_LD[g])) begin
					act_reg[g] <= wdata; // R10
				end
			end
		end
	endgenerate

	// Registers loaded with their reset values on every reset, soft included
	always_ff @(posedge clk_sys) begin
		if (any_hw_rst || soft_reset_reg) begin
			ld4_base_high_reg        <= `CRB_RST_ZERO; // R11
			ld4_base_low_reg         <= `CRB_RST_ZERO;
			ld4_irq_select_reg       <= `CRB_RST_ZERO;
			ld5_base_high_reg        <= `CRB_RST_ZERO;
			ld5_base_low_reg         <= `CRB_RST_ZERO;
			ld5_irq_select_reg       <= `CRB_RST_ZERO;
			keyboard_irq_select_reg  <= `CRB_RST_ZERO;
			pointer_irq_select_reg   <= `CRB_RST_ZERO;
			game_base_high_reg       <= `CRB_RST_ZERO;
			game_base_low_reg        <= `CRB_RST_ZERO;
			wake_block_base_high_reg <= `CRB_RST_ZERO;
			wake_block_base_low_reg  <= `CRB_RST_ZERO;
			midi_base_high_reg       <= `CRB_RST_MIDI_HIGH; // R8
			midi_base_low_reg        <= `CRB_RST_MIDI_LOW;  // R8
			midi_irq_select_reg      <= `CRB_RST_MIDI_IRQ;
		end else if (dat_we) begin
			// Each write lands only in the selected device's copy
			// Serial one
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_HIGH, `CRB_LD_SERIAL_ONE)) begin
				ld4_base_high_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_LOW, `CRB_LD_SERIAL_ONE)) begin
				ld4_base_low_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_IRQ_PRI, `CRB_LD_SERIAL_ONE)) begin
				ld4_irq_select_reg <= wdata;
			end
			// Serial two
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_HIGH, `CRB_LD_SERIAL_TWO)) begin
				ld5_base_high_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_LOW, `CRB_LD_SERIAL_TWO)) begin
				ld5_base_low_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_IRQ_PRI, `CRB_LD_SERIAL_TWO)) begin
				ld5_irq_select_reg <= wdata;
			end
			// Keyboard and pointer
			if (hit(index_reg, ldn_reg, `CRB_IDX_IRQ_PRI, `CRB_LD_KEYBOARD)) begin
				keyboard_irq_select_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_IRQ_SEC, `CRB_LD_KEYBOARD)) begin
				pointer_irq_select_reg <= wdata;
			end
			// Game port
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_HIGH, `CRB_LD_GAME)) begin
				game_base_high_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_LOW, `CRB_LD_GAME)) begin
				game_base_low_reg <= wdata;
			end
			// Wake block
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_HIGH, `CRB_LD_WAKE)) begin
				wake_block_base_high_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_LOW, `CRB_LD_WAKE)) begin
				wake_block_base_low_reg <= wdata;
			end
			// MIDI
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_HIGH, `CRB_LD_MIDI)) begin
				midi_base_high_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_BASE_LOW, `CRB_LD_MIDI)) begin
				midi_base_low_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_IRQ_PRI, `CRB_LD_MIDI)) begin
				midi_irq_select_reg <= wdata;
			end
		end
	end

	// Mode registers: hardware resets only, soft reset keeps them
	always_ff @(posedge clk_sys) begin
		if (any_hw_rst) begin
			serial_one_mode_reg             <= `CRB_RST_ZERO; // R11
			serial_two_mode_reg             <= `CRB_RST_ZERO;
			keyboard_output_select_reg      <= `CRB_RST_ZERO;
			infrared_options_reg            <= `CRB_RST_IR_OPTIONS;
			infrared_halfduplex_timeout_reg <= `CRB_RST_IR_TIMEOUT;
		end else if (dat_we) begin
			// Serial port modes
			if (hit(index_reg, ldn_reg, `CRB_IDX_MODE_0, `CRB_LD_SERIAL_ONE)) begin
				serial_one_mode_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_MODE_0, `CRB_LD_SERIAL_TWO)) begin
				serial_two_mode_reg <= wdata;
			end
			// Infrared settings exist on serial two only
			if (hit(index_reg, ldn_reg, `CRB_IDX_MODE_1, `CRB_LD_SERIAL_TWO)) begin
				infrared_options_reg <= wdata;
			end
			if (hit(index_reg, ldn_reg, `CRB_IDX_MODE_2, `CRB_LD_SERIAL_TWO)) begin
				infrared_halfduplex_timeout_reg <= wdata;
			end
			// Keyboard reset and address gate outputs
			if (hit(index_reg, ldn_reg, `CRB_IDX_MODE_0, `CRB_LD_KEYBOARD)) begin
				keyboard_output_select_reg <= wdata;
			end
		end
	end

	// Slow clock select lives on standby power: only its own reset clears it
	always_ff @(posedge clk_sys) begin
		if (rst_src == CRB_RST_STANDBY) begin
			slow_clock_select_reg <= `CRB_RST_ZERO; // R11
		end else if (dat_we && hit(index_reg, ldn_reg, `CRB_IDX_MODE_0, `CRB_LD_WAKE)) begin
			slow_clock_select_reg <= wdata;
		end
	end

	// Read mux; anything unlisted, reserved or out of range reads zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00; // R3 R6
		if (index_reg <= `CRB_IDX_GLOBAL_LAST) begin
			// Global range, independent of selected device
			case (index_reg) // R1
				`CRB_IDX_LDN:        rd_mux = ldn_reg;
				`CRB_IDX_DEV_ID:     rd_mux = DEV_ID_VALUE;
				`CRB_IDX_DEV_REV:    rd_mux = DEV_REV_VALUE;
				`CRB_IDX_POWER_CTRL: rd_mux = power_ctrl_reg;
				default:             rd_mux = 8'h00; // R3
			endcase
		end else begin
			// Activate sits at the same index in every implemented device
			for (int i = 0; i < 6; i++) begin
				if (hit(index_reg, ldn_reg, `CRB_IDX_ACTIVATE, ACT_LD[i]))
					rd_mux = act_reg[i]; // R9
			end
			case (ldn_reg)
				`CRB_LD_SERIAL_ONE: begin
					case (index_reg)
						`CRB_IDX_BASE_HIGH: rd_mux = ld4_base_high_reg;
						`CRB_IDX_BASE_LOW:  rd_mux = ld4_base_low_reg;
						`CRB_IDX_IRQ_PRI:   rd_mux = ld4_irq_select_reg;
						`CRB_IDX_MODE_0:    rd_mux = serial_one_mode_reg;
						default:            ;
					endcase
				end
				`CRB_LD_SERIAL_TWO: begin
					// 0x62, 0x63, 0x74 stay zero as reserved
					case (index_reg)
						`CRB_IDX_BASE_HIGH: rd_mux = ld5_base_high_reg;
						`CRB_IDX_BASE_LOW:  rd_mux = ld5_base_low_reg;
						`CRB_IDX_IRQ_PRI:   rd_mux = ld5_irq_select_reg;
						`CRB_IDX_MODE_0:    rd_mux = serial_two_mode_reg;
						`CRB_IDX_MODE_1:    rd_mux = infrared_options_reg;
						`CRB_IDX_MODE_2:    rd_mux = infrared_halfduplex_timeout_reg;
						default:            ; // R6
					endcase
				end
				`CRB_LD_KEYBOARD: begin
					case (index_reg)
						`CRB_IDX_IRQ_PRI: rd_mux = keyboard_irq_select_reg;
						`CRB_IDX_IRQ_SEC: rd_mux = pointer_irq_select_reg;
						`CRB_IDX_MODE_0:  rd_mux = keyboard_output_select_reg;
						default:          ;
					endcase
				end
				`CRB_LD_GAME: begin
					case (index_reg)
						`CRB_IDX_BASE_HIGH: rd_mux = game_base_high_reg;
						`CRB_IDX_BASE_LOW:  rd_mux = game_base_low_reg;
						default:            ;
					endcase
				end
				`CRB_LD_WAKE: begin
					// 0xF1 reserved, reads zero
					case (index_reg)
						`CRB_IDX_BASE_HIGH: rd_mux = wake_block_base_high_reg;
						`CRB_IDX_BASE_LOW:  rd_mux = wake_block_base_low_reg;
						`CRB_IDX_MODE_0:    rd_mux = slow_clock_select_reg;
						default:            ; // R6
					endcase
				end
				`CRB_LD_MIDI: begin
					case (index_reg)
						`CRB_IDX_BASE_HIGH: rd_mux = midi_base_high_reg;
						`CRB_IDX_BASE_LOW:  rd_mux = midi_base_low_reg;
						`CRB_IDX_IRQ_PRI:   rd_mux = midi_irq_select_reg;
						default:            ;
					endcase
				end
				default: ; // Unimplemented devices read zero
			endcase
		end
	end

	// Registered read answer, one cycle after the strobe
	// Zero between reads keeps stale data off the port
	always_ff @(posedge clk_sys) begin
		if (any_hw_rst) begin
			rdata       <= 8'h00;
			rdata_valid <= 1'b0;
		end else begin
			rdata_valid <= dat_re; // R5
			rdata       <= dat_re ? rd_mux : 8'h00; // R4
		end
	end

	// Registered status outputs
	always_ff @(posedge clk_sys) begin
		if (any_hw_rst) begin
			index_out      <= 8'h00;
			ldn_out        <= 8'h00;
			power_ctrl_out <= 8'h00;
			activate_out   <= 6'h00;
		end else begin
			index_out      <= index_reg;
			ldn_out        <= ldn_reg;
			power_ctrl_out <= power_ctrl_reg;
			for (int i = 0; i < 6; i++) begin
				activate_out[i] <= act_reg[i][0];
			end
		end
	end

endmodule : crb_config_bank

// ---- tb/crb_bank_checker.sv ----
// Port-level assertions for the configuration register bank
`timescale 1ns/100ps
module crb_bank_checker
	import crb_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       reset,
	input wire logic       main_poweron_reset,
	input wire logic       standby_poweron_reset,
	input wire logic       config_mode,
	input wire logic       index_wr,
	input wire logic       data_wr,
	input wire logic       data_rd,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       rdata_valid,
	input wire logic [7:0] index_out,
	input wire logic [7:0] ldn_out,
	input wire logic [7:0] power_ctrl_out,
	input wire logic [5:0] activate_out
);
	// Any of the three reset sources
	wire any_rst = reset | main_poweron_reset | standby_poweron_reset;
	// Retained power bits as last shown outside reset; standby zeroes them
	logic       rst_seen_reg;
	logic [7:0] kept_bits_reg;
	always_ff @(posedge clk_sys) begin
		rst_seen_reg <= any_rst;
		if (standby_poweron_reset) begin
			kept_bits_reg <= 8'h00;
		end else if (!any_rst && !rst_seen_reg) begin
			kept_bits_reg <= power_ctrl_out & 8'hA0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (any_rst);
	// Host strobes are spaced one idle cycle apart
	sequence soft_req;
		config_mode && index_wr && wdata == 8'h02 ##2 config_mode && data_wr && !index_wr && wdata[0];
	endsequence
	sequence ldn_read;
		config_mode && index_wr && wdata == 8'h07 ##2 config_mode && data_rd && !index_wr && !data_wr;
	endsequence
	// Indexes that no device implements, 0x82 probes upper-bit aliasing
	sequence rsvd_read;
		config_mode && index_wr && (wdata inside {8'h01, 8'h03, 8'h62, 8'h63, 8'h82})
		##2 config_mode && data_rd && !index_wr && !data_wr;
	endsequence
	rd_answer_a: assert property (config_mode && data_rd |=> rdata_valid)
		else $error("read not answered");
	rd_spurious_a: assert property (!(config_mode && data_rd) |=> !rdata_valid)
		else $error("answer without taken read");
	rd_idle_zero_a: assert property (!rdata_valid |-> rdata == 8'h00)
		else $error("rdata not zero when idle");
	rd_ldn_echo_a: assert property (ldn_read |=> rdata == ldn_out)
		else $error("selector read mismatch");
	rd_rsvd_zero_a: assert property (rsvd_read |=> rdata_valid && rdata == 8'h00)
		else $error("reserved index read nonzero");
	idle_mode_hold_a: assert property ((!config_mode) [*3] |=> $stable(index_out) && $stable(ldn_out))
		else $error("state changed outside configuration mode");
	soft_clears_a: assert property (soft_req |-> ##[1:3] ldn_out == 8'h00 && !activate_out[0])
		else $error("soft reset did not clear");
	pwr_keep_a: assert property (rst_seen_reg && !any_rst
		|=> (power_ctrl_out & 8'hA0) == kept_bits_reg)
		else $error("retained power bits wrong after reset");
	standby_clear_a: assert property (disable iff (1'b0)
		standby_poweron_reset [*2] |=> power_ctrl_out == 8'h00 && activate_out == 6'h00)
		else $error("standby reset did not clear");
endmodule : crb_bank_checker
bind crb_config_bank crb_bank_checker chk (.clk_sys, .reset, .main_poweron_reset,
	.standby_poweron_reset, .config_mode, .index_wr, .data_wr, .data_rd, .wdata, .rdata,
	.rdata_valid, .index_out, .ldn_out, .power_ctrl_out, .activate_out);

// ---- tb/crb_host_model.sv ----
// Host model that drives the index and data ports
`timescale 1ns/100ps
module crb_host_model (
	input  wire logic       clk_sys,
	output logic            config_mode,
	output logic            index_wr,
	output logic            data_wr,
	output logic            data_rd,
	output logic      [7:0] wdata,
	input  wire logic [7:0] rdata,
	input  wire logic       rdata_valid
);
	// Idle at time zero, configuration mode entered
	initial begin
		config_mode = 1'b1;
		index_wr = 1'b0;
		data_wr = 1'b0;
		data_rd = 1'b0;
		wdata = 8'h00;
	end
	// Enter or leave configuration mode
	task set_mode(input logic m);
		@(posedge clk_sys);
		config_mode <= m;
	endtask : set_mode
	// One strobe for one cycle; wdata flips after so a stale byte never looks valid
	task strobe(input logic [1:0] kind, input logic [7:0] val);
		@(posedge clk_sys);
		index_wr <= (kind == 2'd0);
		data_wr <= (kind == 2'd1);
		data_rd <= (kind == 2'd2);
		wdata <= val;
		@(posedge clk_sys);
		index_wr <= 1'b0;
		data_wr <= 1'b0;
		data_rd <= 1'b0;
		wdata <= ~val;
	endtask : strobe
	// Select device, then index, then data write
	task write_reg(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] val);
		strobe(2'd0, 8'h07);
		strobe(2'd1, ld);
		strobe(2'd0, idx);
		strobe(2'd1, val);
	endtask : write_reg
	// Answer stands the cycle after the strobe; taken at the edge closing it
	task read_reg(input logic [7:0] ld, input logic [7:0] idx, output logic [7:0] val,
		output logic ok);
		strobe(2'd0, 8'h07);
		strobe(2'd1, ld);
		strobe(2'd0, idx);
		strobe(2'd2, 8'h00);
		@(posedge clk_sys);
		val = rdata;
		ok = rdata_valid;
	endtask : read_reg
endmodule : crb_host_model

// ---- tb/config_register_bank_tb.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
module config_register_bank_tb
	import crb_pkg::*;
;
	typedef struct { logic wr; logic [7:0] ld, idx, wd, exp; } crb_row_t;
	logic clk_sys, reset, main_poweron_reset, standby_poweron_reset;
	logic config_mode, index_wr, data_wr, data_rd, rdata_valid, ok;
	logic [7:0] wdata, rdata, index_out, ldn_out, power_ctrl_out, got;
	logic [5:0] activate_out;
	int bad_count = 0;
	int n_tests = 0;
	// Reset values first, then write and read back; device IDs are arbitrary params
	crb_row_t rows [18] = '{
		'{1'b0, 8'h0B, 8'h60, 8'h00, 8'h03}, '{1'b0, 8'h0B, 8'h61, 8'h00, 8'h30},
		'{1'b0, 8'h0B, 8'h70, 8'h00, 8'h05}, '{1'b0, 8'h05, 8'hF1, 8'h00, 8'h02},
		'{1'b0, 8'h05, 8'hF2, 8'h00, 8'h03}, '{1'b0, 8'h00, 8'h20, 8'h00, 8'hC3},
		'{1'b0, 8'h00, 8'h21, 8'h00, 8'h3C}, '{1'b0, 8'h00, 8'h22, 8'h00, 8'h00},
		'{1'b1, 8'h04, 8'h60, 8'h12, 8'h12}, '{1'b1, 8'h05, 8'h62, 8'hFF, 8'h00},
		'{1'b1, 8'h05, 8'h74, 8'hFF, 8'h00}, '{1'b1, 8'h0A, 8'hF1, 8'hFF, 8'h00},
		'{1'b1, 8'h07, 8'h72, 8'h34, 8'h34}, '{1'b1, 8'h09, 8'h61, 8'h56, 8'h56},
		'{1'b1, 8'h00, 8'h82, 8'hFF, 8'h00}, '{1'b1, 8'h00, 8'h03, 8'hFF, 8'h00},
		'{1'b1, 8'h0A, 8'hF0, 8'h11, 8'h11}, '{1'b0, 8'h09, 8'h07, 8'h00, 8'h09}};
	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	crb_host_model host (.clk_sys, .config_mode, .index_wr, .data_wr, .data_rd, .wdata,
		.rdata, .rdata_valid);
	crb_config_bank #(.DEV_ID_VALUE(8'hC3), .DEV_REV_VALUE(8'h3C)) dut (.clk_sys, .reset,
		.main_poweron_reset, .standby_poweron_reset, .config_mode, .index_wr, .data_wr,
		.data_rd, .wdata, .rdata, .rdata_valid, .index_out, .ldn_out, .power_ctrl_out,
		.activate_out);
	// Compare and count
	task check(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	// Read one register and expect a valid answer
	task rd_chk(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] want);
		host.read_reg(ld, idx, got, ok);
		check(got, want);
		check({7'h00, ok}, 8'h01);
	endtask : rd_chk
	// Two-cycle pulse on one reset source: 0 hard, 1 main, 2 standby
	task pulse(input int which);
		@(posedge clk_sys);
		case (which)
			0: reset <= 1'b1;
			1: main_poweron_reset <= 1'b1;
			default: standby_poweron_reset <= 1'b1;
		endcase
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		main_poweron_reset <= 1'b0;
		standby_poweron_reset <= 1'b0;
		// Status outputs reload one cycle after release
		repeat (2) @(posedge clk_sys);
	endtask : pulse
	// Counts, verdict and end of run
	task end_sim;
		$display("Comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	// Hang guard, far beyond the few hundred cycles the tests take
	initial begin
		#100000;
		bad_count++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		end_sim();
	end
	// Main sequence
	initial begin
		reset = 1'b1;
		main_poweron_reset = 1'b1;
		standby_poweron_reset = 1'b1;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		main_poweron_reset <= 1'b0;
		standby_poweron_reset <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			if (rows[i].wr)
				host.write_reg(rows[i].ld, rows[i].idx, rows[i].wd);
			rd_chk(rows[i].ld, rows[i].idx, rows[i].exp);
		end
		check(index_out, 8'h07);
		$display("Test table done");
		// Activate touches only the selected device
		host.write_reg(8'h04, 8'h30, 8'h01);
		host.write_reg(8'h0B, 8'h30, 8'h01);
		repeat (2) @(posedge clk_sys);
		check({2'b00, activate_out}, 8'h21);
		rd_chk(8'h04, 8'h30, 8'h01);
		$display("Test activate done");
		// Outside configuration mode nothing is taken or answered
		host.set_mode(1'b0);
		host.write_reg(8'h04, 8'h60, 8'hEE);
		check(index_out, 8'h30);
		host.read_reg(8'h04, 8'h60, got, ok);
		check({7'h00, ok}, 8'h00);
		check(got, 8'h00);
		host.set_mode(1'b1);
		rd_chk(8'h04, 8'h60, 8'h12);
		$display("Test config mode done");
		// Soft reset keeps mode regs, ld5 activate and power bits 5,7
		host.write_reg(8'h05, 8'h30, 8'h01);
		host.write_reg(8'h04, 8'hF0, 8'h5C);
		host.write_reg(8'h0B, 8'h60, 8'h77);
		host.write_reg(8'h00, 8'h22, 8'h7D);
		host.write_reg(8'h00, 8'h02, 8'h01);
		repeat (3) @(posedge clk_sys);
		check(ldn_out, 8'h00);
		check({2'b00, activate_out}, 8'h02);
		check(power_ctrl_out, 8'h20);
		rd_chk(8'h04, 8'hF0, 8'h5C);
		rd_chk(8'h0B, 8'h60, 8'h03);
		rd_chk(8'h04, 8'h60, 8'h00);
		$display("Test soft reset done");
		// Hard and main-supply resets
		for (int k = 0; k < 2; k++) begin
			host.write_reg(8'h04, 8'hF0, 8'h5C);
			host.write_reg(8'h0B, 8'h61, 8'h99);
			host.write_reg(8'h00, 8'h22, 8'h7D);
			pulse(k);
			check(power_ctrl_out, 8'h20);
			check({2'b00, activate_out}, 8'h02);
			rd_chk(8'h04, 8'hF0, 8'h00);
			rd_chk(8'h0B, 8'h61, 8'h30);
			rd_chk(8'h0A, 8'hF0, 8'h11);
		end
		$display("Test hard resets done");
		// Standby power-on clears power bits, ld5 activate and slow clock too
		pulse(2);
		check(power_ctrl_out, 8'h00);
		check({2'b00, activate_out}, 8'h00);
		rd_chk(8'h0A, 8'hF0, 8'h00);
		$display("Test standby reset done");
		end_sim();
	end
endmodule : config_register_bank_tb
